// ===== rtl/dasc_dev.sv
`timescale 1ns/1ns

// Function
// RL1: Chip select fall samples and starts conversion
// RL2: Host holds select low ten edges; dasc_host holds it for cs_len edges, which may be fewer
// RL3: Rise at edges 10..15 aborts, floats lines
// RL4: One result takes sixteen serial clocks
// RL5: Keep driving after sixteen until rise
// RL6: Next sixteen clocks carry other result
// RL7: Status bits name the source converter
// RL8: Release line at the 32nd falling edge
// RL9: Early select rise releases line immediately
// RL10: Host may idle select low after 32
// RL11: Host waits idle gap before next fall
// RL12: Exactly three states: normal, partial, full
// RL13: Rise position picks power state change
// RL14: Reference select low uses internal 2.5 V
// RL15: Reference select high accepts external reference
// RL16: Rise at edges 2..9 enters partial
// RL17: Rise before edge 2 keeps state
// RL18: Partial plus early rise enters full
// RL19: Power-down wakes when held past ten
// RL20: Count edges, clear and float while high
module dasc_dev (
    // Link
    dasc_link_if.dev                       link,
    // Reset
    input  wire logic                      rst_n,
    // Converter results and reference strap
    input  wire logic [dasc_pkg::DATA_W-1:0] conv_a,
    input  wire logic [dasc_pkg::DATA_W-1:0] conv_b,
    input  wire logic                      ref_select,
    // Status
    output dasc_pkg::dasc_pwr_e            pwr_state,
    output logic                           powering_up,
    output logic                           conv_start,
    output logic                           conv_abort,
    output logic                           result_done,
    output logic                           ref_external,
    output logic [11:0]                    vref_mv
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int FW = dasc_pkg::FRAME_W;
    localparam int DW = dasc_pkg::DATA_W;

    logic [DW-1:0]             conv_a_s1_r;
    logic [DW-1:0]             conv_a_s2_r;
    logic [DW-1:0]             conv_b_s1_r;
    logic [DW-1:0]             conv_b_s2_r;
    logic                      ref_s1_r;
    logic                      ref_s2_r;

    logic                      cs_q_r;
    logic                      cs_q_nxt;
    logic [dasc_pkg::CNT_W-1:0] cnt_r;
    logic [dasc_pkg::CNT_W-1:0] cnt_nxt;
    logic [FW-1:0]             sh_a_r;
    logic [FW-1:0]             sh_a_nxt;
    logic [FW-1:0]             sh_b_r;
    logic [FW-1:0]             sh_b_nxt;
    dasc_pkg::dasc_pwr_e       pwr_r;
    dasc_pkg::dasc_pwr_e       pwr_nxt;
    logic                      wake_r;
    logic                      wake_nxt;
    logic                      start_r;
    logic                      start_nxt;
    logic                      abort_r;
    logic                      abort_nxt;
    logic                      done_r;
    logic                      done_nxt;
    logic                      ref_ext_r;
    logic                      ref_ext_nxt;
    logic                      fall_ev;
    logic                      rise_ev;
    logic                      drive_en;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic dasc_pkg::dasc_pwr_e pwr_on_rise(
        input dasc_pkg::dasc_pwr_e      cur,
        input logic [dasc_pkg::CNT_W-1:0] n
    );
        dasc_pkg::dasc_pwr_e res;
        res = cur;
        if (n < dasc_pkg::EDGE_GLITCH) begin
            res = cur;                                      // RL17
        end else if (n < dasc_pkg::EDGE_KEEP) begin
            if (cur == dasc_pkg::DASC_NORMAL) begin
                res = dasc_pkg::DASC_PARTIAL;               // RL16
            end else begin
                res = dasc_pkg::DASC_FULL;                  // RL18
            end
        end else begin
            res = dasc_pkg::DASC_NORMAL;                    // RL19
        end
        return res;                                         // RL13
    endfunction : pwr_on_rise

    function automatic logic [FW-1:0] frame_of(
        input logic [3:0]    s0,
        input logic [DW-1:0] d0,
        input logic [3:0]    s1,
        input logic [DW-1:0] d1
    );
        return {s0, d0, s1, d1};                            // RL7
    endfunction : frame_of

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    always_ff @(negedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            conv_a_s1_r <= '0;
            conv_a_s2_r <= '0;
            conv_b_s1_r <= '0;
            conv_b_s2_r <= '0;
            ref_s1_r    <= 1'b0;
            ref_s2_r    <= 1'b0;
        end else begin
            conv_a_s1_r <= conv_a;
            conv_a_s2_r <= conv_a_s1_r;
            conv_b_s1_r <= conv_b;
            conv_b_s2_r <= conv_b_s1_r;
            ref_s1_r    <= ref_select;
            ref_s2_r    <= ref_s1_r;
        end
    end

    // ****************************************************************
    // Conversion sequencing
    // ****************************************************************
    assign fall_ev = cs_q_r & ~link.cs_n;
    assign rise_ev = ~cs_q_r & link.cs_n;

    always_comb begin
        cs_q_nxt    = link.cs_n;
        cnt_nxt     = cnt_r;
        sh_a_nxt    = sh_a_r;
        sh_b_nxt    = sh_b_r;
        pwr_nxt     = pwr_r;
        wake_nxt    = 1'b0;
        start_nxt   = fall_ev;                              // RL1
        abort_nxt   = 1'b0;
        done_nxt    = 1'b0;
        ref_ext_nxt = ref_s2_r;
        if (link.cs_n) begin
            cnt_nxt  = '0;                                  // RL20
            sh_a_nxt = frame_of(dasc_pkg::STATUS_A, conv_a_s2_r,
                                dasc_pkg::STATUS_B, conv_b_s2_r); // RL1
            sh_b_nxt = frame_of(dasc_pkg::STATUS_B, conv_b_s2_r,
                                dasc_pkg::STATUS_A, conv_a_s2_r); // RL6
            if (rise_ev) begin
                pwr_nxt   = pwr_on_rise(pwr_r, cnt_r);
                abort_nxt = (cnt_r >= dasc_pkg::EDGE_GLITCH) &&
                            (cnt_r <  dasc_pkg::EDGE_WORD);  // RL3
            end
        end else begin
            if (cnt_r != dasc_pkg::EDGE_MAX) begin
                cnt_nxt = cnt_r + 6'h01;
            end
            sh_a_nxt = {sh_a_r[FW-2:0], 1'b0};
            sh_b_nxt = {sh_b_r[FW-2:0], 1'b0};
            wake_nxt = (pwr_r != dasc_pkg::DASC_NORMAL);    // RL19
            done_nxt = (cnt_nxt == dasc_pkg::EDGE_WORD) &&
                       (cnt_r != dasc_pkg::EDGE_WORD);      // RL4
        end
    end

    always_ff @(negedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            cs_q_r    <= 1'b1;
            cnt_r     <= '0;
            sh_a_r    <= '0;
            sh_b_r    <= '0;
            pwr_r     <= dasc_pkg::DASC_NORMAL;             // RL12
            wake_r    <= 1'b0;
            start_r   <= 1'b0;
            abort_r   <= 1'b0;
            done_r    <= 1'b0;
            ref_ext_r <= 1'b0;
        end else begin
            cs_q_r    <= cs_q_nxt;
            cnt_r     <= cnt_nxt;
            sh_a_r    <= sh_a_nxt;
            sh_b_r    <= sh_b_nxt;
            pwr_r     <= pwr_nxt;
            wake_r    <= wake_nxt;
            start_r   <= start_nxt;
            abort_r   <= abort_nxt;
            done_r    <= done_nxt;
            ref_ext_r <= ref_ext_nxt;
        end
    end

    // ****************************************************************
    // Result lines
    // ****************************************************************
    // Enable follows the select pin directly so a rise floats at once
    assign drive_en = rst_n & ~link.cs_n &
                      (cnt_r < dasc_pkg::EDGE_FRAME);       // RL5 RL8 RL9 RL20 RL3

    assign link.result_line_a    = sh_a_r[FW-1];            // RL6
    assign link.result_line_b    = sh_b_r[FW-1];
    assign link.result_line_a_oe = drive_en;
    assign link.result_line_b_oe = drive_en;

    // ****************************************************************
    // Status outputs
    // ****************************************************************
    assign pwr_state    = pwr_r;
    assign powering_up  = wake_r;
    assign conv_start   = start_r;
    assign conv_abort   = abort_r;
    assign result_done  = done_r;
    assign ref_external = ref_ext_r;                        // RL15
    assign vref_mv      = ref_ext_r ? 12'h000 :
                          dasc_pkg::INT_REF_MV;             // RL14

endmodule : dasc_dev

// ===== rtl/dasc_pkg.sv
package dasc_pkg;

    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam int          DATA_W     = 12;
    localparam int          STAT_W     = 4;
    localparam int          WORD_W     = STAT_W + DATA_W;
    localparam int          FRAME_W    = 2 * WORD_W;
    localparam int          CNT_W      = 6;
    localparam logic [3:0]  STATUS_A   = 4'h0;
    localparam logic [3:0]  STATUS_B   = 4'h1;

    // ****************************************************************
    // Serial clock falling-edge counts
    // ****************************************************************
    localparam logic [5:0]  EDGE_GLITCH = 6'h02;
    localparam logic [5:0]  EDGE_KEEP   = 6'h0a;
    localparam logic [5:0]  EDGE_WORD   = 6'h10;
    localparam logic [5:0]  EDGE_FRAME  = 6'h20;
    localparam logic [5:0]  EDGE_MAX    = 6'h3f;

    // ****************************************************************
    // Reference and timing
    // ****************************************************************
    localparam logic [11:0] INT_REF_MV      = 12'h9c4;
    localparam int          CORE_CLK_PS     = 8000;
    localparam int          BUS_IDLE_GAP_NS = 50;
    localparam int          BUS_IDLE_GAP_CYC =
        (BUS_IDLE_GAP_NS * 1000 + CORE_CLK_PS - 1) / CORE_CLK_PS;
    localparam int          SCLK_HALF       = 4;

    // ****************************************************************
    // Operating states
    // ****************************************************************
    typedef enum logic [1:0] {
        DASC_NORMAL,
        DASC_PARTIAL,
        DASC_FULL
    } dasc_pwr_e;

    typedef enum logic [1:0] {
        DASC_H_IDLE,
        DASC_H_ARM,
        DASC_H_LOW,
        DASC_H_GAP
    } dasc_hst_e;

endpackage : dasc_pkg

// ===== rtl/dasc_link_if.sv
`timescale 1ns/1ns
interface dasc_link_if;

    // Host-driven lines
    logic cs_n;
    logic sclk;
    // Device result lines with enables
    logic result_line_a;
    logic result_line_a_oe;
    logic result_line_b;
    logic result_line_b_oe;
    // Resolved wire levels
    wire  result_line_a_wire;
    wire  result_line_b_wire;

    // Released lines read inverted so a late sample shows up
    assign result_line_a_wire = result_line_a_oe ? result_line_a :
                                ~result_line_a;
    assign result_line_b_wire = result_line_b_oe ? result_line_b :
                                ~result_line_b;

    modport dev (
        input  cs_n,
        input  sclk,
        output result_line_a,
        output result_line_a_oe,
        output result_line_b,
        output result_line_b_oe
    );

    modport host (
        output cs_n,
        output sclk,
        input  result_line_a,
        input  result_line_a_oe,
        input  result_line_b,
        input  result_line_b_oe,
        input  result_line_a_wire,
        input  result_line_b_wire
    );

endinterface : dasc_link_if

// ===== rtl/dasc_host.sv
`timescale 1ns/1ns
module dasc_host #(
    parameter int SCLK_HALF = dasc_pkg::SCLK_HALF
) (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    // Link
    dasc_link_if.host                         link,
    // Request
    input  wire logic                         start,
    input  wire logic [dasc_pkg::CNT_W-1:0]   cs_len,
    // Answer
    output logic                              busy,
    output logic                              done,
    output logic [dasc_pkg::FRAME_W-1:0]      rx_a,
    output logic [dasc_pkg::FRAME_W-1:0]      rx_b
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int FW = dasc_pkg::FRAME_W;
    localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
    localparam logic [7:0] GAP_CYC = 8'(dasc_pkg::BUS_IDLE_GAP_CYC);

    logic                       da_s1_r;
    logic                       da_s2_r;
    logic                       db_s1_r;
    logic                       db_s2_r;

    logic [7:0]                 div_r;
    logic [7:0]                 div_nxt;
    logic                       sclk_r;
    logic                       sclk_nxt;
    dasc_pkg::dasc_hst_e        st_r;
    dasc_pkg::dasc_hst_e        st_nxt;
    logic                       cs_n_r;
    logic                       cs_n_nxt;
    logic [dasc_pkg::CNT_W-1:0] edges_r;
    logic [dasc_pkg::CNT_W-1:0] edges_nxt;
    logic [dasc_pkg::CNT_W-1:0] len_r;
    logic [dasc_pkg::CNT_W-1:0] len_nxt;
    logic [7:0]                 gap_r;
    logic [7:0]                 gap_nxt;
    logic [FW-1:0]              sh_a_r;
    logic [FW-1:0]              sh_a_nxt;
    logic [FW-1:0]              sh_b_r;
    logic [FW-1:0]              sh_b_nxt;
    logic [FW-1:0]              rx_a_r;
    logic [FW-1:0]              rx_a_nxt;
    logic [FW-1:0]              rx_b_r;
    logic [FW-1:0]              rx_b_nxt;
    logic                       done_r;
    logic                       done_nxt;
    logic                       tog;
    logic                       rise_ev;
    logic                       fall_ev;

    // ****************************************************************
    // Result line synchronisers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            da_s1_r <= 1'b0;
            da_s2_r <= 1'b0;
            db_s1_r <= 1'b0;
            db_s2_r <= 1'b0;
        end else begin
            da_s1_r <= link.result_line_a_wire;
            da_s2_r <= da_s1_r;
            db_s1_r <= link.result_line_b_wire;
            db_s2_r <= db_s1_r;
        end
    end

    // ****************************************************************
    // Transfer control
    // ****************************************************************
    assign tog     = (div_r == HALF_M1);
    assign rise_ev = tog & ~sclk_r;
    assign fall_ev = tog & sclk_r;

    always_comb begin
        div_nxt   = tog ? 8'h00 : div_r + 8'h01;
        sclk_nxt  = tog ? ~sclk_r : sclk_r;
        st_nxt    = st_r;
        cs_n_nxt  = cs_n_r;
        edges_nxt = edges_r;
        len_nxt   = len_r;
        gap_nxt   = gap_r;
        sh_a_nxt  = sh_a_r;
        sh_b_nxt  = sh_b_r;
        rx_a_nxt  = rx_a_r;
        rx_b_nxt  = rx_b_r;
        done_nxt  = 1'b0;
        unique case (st_r)
            dasc_pkg::DASC_H_IDLE: begin
                if (start) begin
                    len_nxt = cs_len;
                    st_nxt  = dasc_pkg::DASC_H_ARM;
                end
            end
            dasc_pkg::DASC_H_ARM: begin
                if (rise_ev) begin
                    cs_n_nxt  = 1'b0;
                    edges_nxt = '0;
                    sh_a_nxt  = '0;
                    sh_b_nxt  = '0;
                    st_nxt    = dasc_pkg::DASC_H_LOW;
                end
            end
            dasc_pkg::DASC_H_LOW: begin
                if (fall_ev && edges_r != dasc_pkg::EDGE_MAX) begin
                    edges_nxt = edges_r + 6'h01;
                    if (edges_r < dasc_pkg::EDGE_FRAME) begin
                        sh_a_nxt = {sh_a_r[FW-2:0], da_s2_r};
                        sh_b_nxt = {sh_b_r[FW-2:0], db_s2_r};
                    end
                end
                if (rise_ev && edges_r >= len_r) begin      // RL2
                    cs_n_nxt = 1'b1;                        // RL10
                    rx_a_nxt = sh_a_r;
                    rx_b_nxt = sh_b_r;
                    done_nxt = 1'b1;
                    gap_nxt  = GAP_CYC;
                    st_nxt   = dasc_pkg::DASC_H_GAP;
                end
            end
            dasc_pkg::DASC_H_GAP: begin
                if (gap_r <= 8'h01) begin
                    gap_nxt = 8'h00;
                    st_nxt  = dasc_pkg::DASC_H_IDLE;        // RL11
                end else begin
                    gap_nxt = gap_r - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r   <= 8'h00;
            sclk_r  <= 1'b1;
            st_r    <= dasc_pkg::DASC_H_IDLE;
            cs_n_r  <= 1'b1;
            edges_r <= '0;
            len_r   <= '0;
            gap_r   <= 8'h00;
            sh_a_r  <= '0;
            sh_b_r  <= '0;
            rx_a_r  <= '0;
            rx_b_r  <= '0;
            done_r  <= 1'b0;
        end else begin
            div_r   <= div_nxt;
            sclk_r  <= sclk_nxt;
            st_r    <= st_nxt;
            cs_n_r  <= cs_n_nxt;
            edges_r <= edges_nxt;
            len_r   <= len_nxt;
            gap_r   <= gap_nxt;
            sh_a_r  <= sh_a_nxt;
            sh_b_r  <= sh_b_nxt;
            rx_a_r  <= rx_a_nxt;
            rx_b_r  <= rx_b_nxt;
            done_r  <= done_nxt;
        end
    end

    assign link.sclk = sclk_r;
    assign link.cs_n = cs_n_r;
    assign busy      = (st_r != dasc_pkg::DASC_H_IDLE);
    assign done      = done_r;
    assign rx_a      = rx_a_r;
    assign rx_b      = rx_b_r;

endmodule : dasc_host

// ===== dv/dasc_assertions.sv
`timescale 1ns/1ns
module dasc_assertions (
    // Reset
    input wire logic rst_n,
    // Link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic result_line_a,
    input wire logic result_line_a_oe,
    input wire logic result_line_b,
    input wire logic result_line_b_oe
);
    // ****************************************************************
    // Falling edges seen since chip select fell
    // ****************************************************************
    logic [5:0] edge_cnt_r;
    logic [5:0] edge_cnt_nxt;

    always_comb begin
        edge_cnt_nxt = edge_cnt_r;
        if (cs_n) begin
            edge_cnt_nxt = 6'h00;
        end else if (edge_cnt_r != dasc_pkg::EDGE_MAX) begin
            edge_cnt_nxt = edge_cnt_r + 6'h01;
        end
    end

    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt_r <= 6'h00;
        end else begin
            edge_cnt_r <= edge_cnt_nxt;
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(negedge sclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_abort_win;
        !cs_n && edge_cnt_r inside {[6'h0a:6'h0f]} ##1 cs_n;
    endsequence
    sequence s_word_done;
        !cs_n && edge_cnt_r == dasc_pkg::EDGE_WORD;
    endsequence

    property p_float_idle;
        cs_n |-> !result_line_a_oe && !result_line_b_oe;
    endproperty
    property p_drive_frame;
        !cs_n && edge_cnt_r < dasc_pkg::EDGE_FRAME
            |-> result_line_a_oe && result_line_b_oe;
    endproperty
    property p_release_32;
        !cs_n && edge_cnt_r >= dasc_pkg::EDGE_FRAME
            |-> !result_line_a_oe && !result_line_b_oe;
    endproperty
    property p_status_a;
        !cs_n && edge_cnt_r < 6'h04
            |-> result_line_a == dasc_pkg::STATUS_A[2'h3 - edge_cnt_r[1:0]];
    endproperty
    property p_status_b;
        !cs_n && edge_cnt_r < 6'h04
            |-> result_line_b == dasc_pkg::STATUS_B[2'h3 - edge_cnt_r[1:0]];
    endproperty
    property p_status_second;
        !cs_n && edge_cnt_r inside {[6'h10:6'h13]}
            |-> result_line_a == dasc_pkg::STATUS_B[2'h3 - edge_cnt_r[1:0]];
    endproperty
    property p_abort_float;
        s_abort_win |-> !result_line_a_oe && !result_line_b_oe
            ##1 !result_line_a_oe;
    endproperty
    property p_keep_after16;
        s_word_done ##1 !cs_n |-> result_line_a_oe && result_line_b_oe;
    endproperty
    property p_oe_pair;
        result_line_a_oe == result_line_b_oe;
    endproperty

    a_float_idle: assert property (p_float_idle)
        else $error("result line driven while chip select high");
    a_drive_frame: assert property (p_drive_frame)
        else $error("result line not driven inside frame");
    a_release_32: assert property (p_release_32)
        else $error("result line driven after 32 edges");
    a_status_a: assert property (p_status_a)
        else $error("wrong leading status on line a");
    a_status_b: assert property (p_status_b)
        else $error("wrong leading status on line b");
    a_status_second: assert property (p_status_second)
        else $error("wrong status before second result");
    a_abort_float: assert property (p_abort_float)
        else $error("lines not floated after late abort");
    a_keep_after16: assert property (p_keep_after16)
        else $error("line released after 16 edges with select low");
    a_oe_pair: assert property (p_oe_pair)
        else $error("result line enables differ");
endmodule : dasc_assertions

// ===== dv/test_dual_adc_serial_conv_control.sv
`timescale 1ns/1ns
module test_dual_adc_serial_conv_control;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int       TIME_LIMIT = 20000;
    logic                core_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                start = 1'b0;
    logic [5:0]          cs_len = 6'h00;
    logic [11:0]         conv_a = 12'h5a3;
    logic [11:0]         conv_b = 12'hc3e;
    logic                ref_select = 1'b0;
    logic                busy;
    logic                done;
    logic [31:0]         rx_a;
    logic [31:0]         rx_b;
    dasc_pkg::dasc_pwr_e pwr_state;
    logic                powering_up;
    logic                conv_start;
    logic                conv_abort;
    logic                result_done;
    logic                ref_external;
    logic [11:0]         vref_mv;
    logic                seen_start, seen_abort, seen_done, seen_pwrup;
    int                  fail_count = 0;
    int                  cmp_count = 0;
    int                  cycle_cnt = 0;

    dasc_link_if link ();

    dasc_host u_dasc_host (.core_clk(core_clk), .rst_n(rst_n), .link(link),
        .start(start), .cs_len(cs_len), .busy(busy), .done(done),
        .rx_a(rx_a), .rx_b(rx_b));

    dasc_dev u_dasc_dev (.link(link), .rst_n(rst_n), .conv_a(conv_a),
        .conv_b(conv_b), .ref_select(ref_select), .pwr_state(pwr_state),
        .powering_up(powering_up), .conv_start(conv_start),
        .conv_abort(conv_abort), .result_done(result_done),
        .ref_external(ref_external), .vref_mv(vref_mv));

    dasc_assertions u_dasc_assertions (.rst_n(rst_n), .cs_n(link.cs_n),
        .sclk(link.sclk), .result_line_a(link.result_line_a),
        .result_line_a_oe(link.result_line_a_oe),
        .result_line_b(link.result_line_b),
        .result_line_b_oe(link.result_line_b_oe));

    always #4 core_clk = ~core_clk;

    always @(posedge conv_start) seen_start = 1'b1;
    always @(posedge conv_abort) seen_abort = 1'b1;
    always @(posedge result_done) seen_done = 1'b1;
    always @(posedge powering_up) seen_pwrup = 1'b1;

    always @(posedge core_clk) begin
        cycle_cnt++;
        if (cycle_cnt == TIME_LIMIT) begin
            fail_count++;
            stop_test();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic wait_level(ref logic sig, input logic lvl);
        int k;
        k = 0;
        while (sig !== lvl && k < 1000) begin
            @(negedge core_clk);
            k++;
        end
        if (k == 1000) begin
            fail_count++;
            stop_test();
        end
    endtask : wait_level

    // One framed transfer of n edges, then the resulting state
    task automatic xfer(input logic [5:0] n, input dasc_pkg::dasc_pwr_e st);
        logic [31:0] fa;
        logic [31:0] fb;
        logic [31:0] mask;
        logic        was_down;
        logic [5:0]  m;
        repeat (32) @(negedge core_clk);
        fa = {dasc_pkg::STATUS_A, conv_a, dasc_pkg::STATUS_B, conv_b};
        fb = {dasc_pkg::STATUS_B, conv_b, dasc_pkg::STATUS_A, conv_a};
        m = (n > 6'h20) ? 6'h20 : n;
        mask = 32'hffffffff >> (32 - m);
        was_down = (pwr_state != dasc_pkg::DASC_NORMAL);
        seen_start = 1'b0;
        seen_abort = 1'b0;
        seen_done = 1'b0;
        seen_pwrup = 1'b0;
        start = 1'b1;
        cs_len = n;
        @(negedge core_clk);
        start = 1'b0;
        wait_level(done, 1'b1);
        check(rx_a & mask, fa >> (32 - m));
        check(rx_b & mask, fb >> (32 - m));
        wait_level(busy, 1'b0);
        repeat (24) @(negedge core_clk);
        check(32'(pwr_state), 32'(st));
        check({31'h0, seen_start}, {31'h0, n != 6'h00});
        check({31'h0, seen_abort}, {31'h0, n >= 6'h02 && n <= 6'h0f});
        check({31'h0, seen_done}, {31'h0, n >= 6'h10});
        check({31'h0, seen_pwrup}, {31'h0, was_down});
    endtask : xfer

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (32) @(negedge core_clk);
        check({20'h0, vref_mv}, {20'h0, dasc_pkg::INT_REF_MV});
        check({31'h0, ref_external}, 32'h0);
        xfer(6'h20, dasc_pkg::DASC_NORMAL);
        xfer(6'h10, dasc_pkg::DASC_NORMAL);
        xfer(6'h0c, dasc_pkg::DASC_NORMAL);
        xfer(6'h01, dasc_pkg::DASC_NORMAL);
        xfer(6'h05, dasc_pkg::DASC_PARTIAL);
        xfer(6'h01, dasc_pkg::DASC_PARTIAL);
        xfer(6'h09, dasc_pkg::DASC_FULL);
        xfer(6'h02, dasc_pkg::DASC_FULL);
        xfer(6'h0a, dasc_pkg::DASC_NORMAL);
        xfer(6'h02, dasc_pkg::DASC_PARTIAL);
        xfer(6'h14, dasc_pkg::DASC_NORMAL);
        conv_a = 12'h0ff;
        conv_b = 12'hf00;
        ref_select = 1'b1;
        xfer(6'h28, dasc_pkg::DASC_NORMAL);
        xfer(6'h20, dasc_pkg::DASC_NORMAL);
        check({20'h0, vref_mv}, 32'h0);
        check({31'h0, ref_external}, 32'h1);
        stop_test();
    end
endmodule : test_dual_adc_serial_conv_control
